//--- src/ccs_consts.vh
// register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH

// byte addresses on the register bus
`define CCS_OFF_CHSEL      4'h0
`define CCS_OFF_CTLA       4'h4
`define CCS_OFF_CTLB       4'h8
`define CCS_OFF_RESULT     4'hC

// channel/reference select fields
`define CCS_CH_REF_BIT     6
`define CCS_CH_LJ_BIT      5
`define CCS_CH_TEMP_CODE   4'h8
`define CCS_CH_RST         8'h00

// control/status a fields
`define CCS_A_ON_BIT       7
`define CCS_A_GO_BIT       6
`define CCS_A_AUTO_BIT     5
`define CCS_A_DONE_BIT     4
`define CCS_A_IE_BIT       3
`define CCS_A_RST          8'h00

// trigger source code for free running
`define CCS_TRIG_FREE      3'h0

// conversion lengths in converter clock cycles
`define CCS_FIRST_CYCLES   5'd25
`define CCS_NORM_CYCLES    5'd13

// answer codes of the register bus
`define CCS_RESP_OKAY      2'h0
`define CCS_RESP_SLVERR    2'h2

`endif

//--- src/ccs_prescaler.v
// converter clock prescaler producing one-cycle tick pulses
`timescale 1ns/1ns
`default_nettype none

module ccs_prescaler #(
    parameter W = 7
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         run,
    input  wire [2:0]   divSel,
    output reg          tick
);
    reg  [W-1:0] count_r;
    reg  [W-1:0] limit;

    // division factor minus one; codes 0 and 1 both give 2
    always @* begin
        case (divSel)
            3'h0, 3'h1: limit = 7'h01;
            3'h2:       limit = 7'h03;
            3'h3:       limit = 7'h07;
            3'h4:       limit = 7'h0F;
            3'h5:       limit = 7'h1F;
            3'h6:       limit = 7'h3F;
            default:    limit = 7'h7F;
        endcase
    end

    // counter held at zero while off, so ticks align with enabling
    always @(posedge clk) begin
        if (rst || !run) begin
            count_r <= {W{1'b0}};
            tick    <= 1'b0;
        end else if (count_r >= limit) begin
            count_r <= {W{1'b0}};
            tick    <= 1'b1;
        end else begin
            count_r <= count_r + 1'b1;
            tick    <= 1'b0;
        end
    end
endmodule

`default_nettype wire

//--- src/ccs_sequencer.v
// converter control sequencer: register file, conversion timing and result registers
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ccs_consts.vh"

module ccs_sequencer (
    input  wire         clk,
    input  wire         rst,
    // register bus
    input  wire [3:0]   s_axi_awaddr,
    input  wire         s_axi_awvalid,
    output wire         s_axi_awready,
    input  wire [31:0]  s_axi_wdata,
    input  wire [3:0]   s_axi_wstrb,
    input  wire         s_axi_wvalid,
    output wire         s_axi_wready,
    output reg  [1:0]   s_axi_bresp,
    output reg          s_axi_bvalid,
    input  wire         s_axi_bready,
    input  wire [3:0]   s_axi_araddr,
    input  wire         s_axi_arvalid,
    output wire         s_axi_arready,
    output reg  [31:0]  s_axi_rdata,
    output reg  [1:0]   s_axi_rresp,
    output reg          s_axi_rvalid,
    input  wire         s_axi_rready,
    // analog core
    output reg  [3:0]   analogChannel,
    output reg          analogRefSupply,
    output reg          tempSensorOn,
    output reg          analogSample,
    input  wire [9:0]   analogCode,
    // trigger sources, already on this clock
    input  wire [7:0]   triggerSources,
    // processor side
    input  wire         globalIrqEnable,
    input  wire         irqAck,
    output wire         convDoneIrq,
    output wire         readLowStrobe,
    output wire         readHighStrobe
);
    //------------------------------------------------------------------
    // register word addresses and the live bits of the select register
    //------------------------------------------------------------------
    localparam [3:0] OFF_CHSEL    = `CCS_OFF_CHSEL;
    localparam [3:0] OFF_CTLA     = `CCS_OFF_CTLA;
    localparam [3:0] OFF_CTLB     = `CCS_OFF_CTLB;
    localparam [3:0] OFF_RESULT   = `CCS_OFF_RESULT;
    localparam [7:0] CH_LIVE_BITS = 8'h6F; // bits 7 and 4 unused

    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    reg  [7:0]   chSel_r;       // software copy of select register
    reg          convOn_r;
    reg          autoOn_r;
    reg          doneFlag_r;
    reg          irqEn_r;
    reg  [2:0]   divSel_r;
    reg  [2:0]   trigSel_r;
    reg          busy_r;
    reg          startPend_r;
    reg          firstConv_r;   // next conversion must initialise
    reg  [4:0]   cycLeft_r;
    reg  [9:0]   result_r;
    reg  [9:0]   shadow_r;      // holds pair steady between byte reads
    reg          lowRead_r;
    reg          trigPrev_r;
    reg          awHeld_r;
    reg          wHeld_r;
    reg  [3:0]   awAddr_r;
    reg  [31:0]  wData_r;
    reg  [3:0]   wStrb_r;

    wire         tick;
    wire         trigLevel;
    wire         trigRise;
    wire         wrFire;
    wire         rdFire;
    wire [3:0]   wrAddr;
    wire [31:0]  wrData;
    wire [3:0]   wrStrb;
    wire         wrChSel;
    wire         wrCtlA;
    wire         wrCtlB;
    wire         finish;
    wire         freeRun;
    wire [15:0]  resultView;
    wire [9:0]   shownCode;
    wire         onWrite;
    wire         offWrite;
    wire         swStart;
    wire         abortNow;
    wire         resultRd;

    //------------------------------------------------------------------
    // write channel: address and data taken in either order
    //------------------------------------------------------------------
    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
    assign wrAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
    assign wrData = wHeld_r ? wData_r : s_axi_wdata;
    assign wrStrb = wHeld_r ? wStrb_r : s_axi_wstrb;
    assign wrFire = (awHeld_r || s_axi_awvalid) && (wHeld_r || s_axi_wvalid) && !s_axi_bvalid;
    assign wrChSel = wrFire && wrStrb[0] && (wrAddr[3:2] == OFF_CHSEL[3:2]);
    assign wrCtlA  = wrFire && wrStrb[0] && (wrAddr[3:2] == OFF_CTLA[3:2]);
    assign wrCtlB  = wrFire && wrStrb[0] && (wrAddr[3:2] == OFF_CTLB[3:2]);

    // hold whichever half arrives first, answer once both are in
    // neither half of the next write is taken before the answer is
    always @(posedge clk) begin
        if (rst) begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            awAddr_r     <= 4'h0;
            wData_r      <= 32'h0000_0000;
            wStrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CCS_RESP_OKAY;
        end else begin
            if (wrFire) begin
                awHeld_r     <= 1'b0;
                wHeld_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // result word is read only
                s_axi_bresp  <= (wrAddr[3:2] == OFF_RESULT[3:2]) ?
                                `CCS_RESP_SLVERR : `CCS_RESP_OKAY;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    awHeld_r <= 1'b1;
                    awAddr_r <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    wHeld_r <= 1'b1;
                    wData_r <= s_axi_wdata;
                    wStrb_r <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------------
    // converter clock
    //------------------------------------------------------------------
    // counter held while off, so the first tick is a full period after enabling
    ccs_prescaler #(
        .W      (7)
    ) ccs_prescaler_inst (
        .clk    (clk),
        .rst    (rst),
        .run    (convOn_r),
        .divSel (divSel_r),
        .tick   (tick)
    );

    //------------------------------------------------------------------
    // trigger edge detect; free running triggers on completion instead
    //------------------------------------------------------------------
    assign freeRun   = (trigSel_r == `CCS_TRIG_FREE);
    assign trigLevel = freeRun ? 1'b0 : triggerSources[trigSel_r];
    assign trigRise  = trigLevel && !trigPrev_r;
    assign finish    = busy_r && tick && (cycLeft_r == 5'd1);

    always @(posedge clk) begin
        if (rst)
            trigPrev_r <= 1'b0;
        else
            trigPrev_r <= trigLevel;
    end

    //------------------------------------------------------------------
    // start and abort requests
    //------------------------------------------------------------------
    // enabling and starting in one write must survive the old enable state
    assign onWrite  = wrCtlA && wrData[`CCS_A_ON_BIT];
    assign offWrite = wrCtlA && !wrData[`CCS_A_ON_BIT];
    assign swStart  = onWrite && wrData[`CCS_A_GO_BIT];
    // writing zero to the start bit leaves a running conversion alone
    assign abortNow = offWrite || (!convOn_r && !onWrite);

    //------------------------------------------------------------------
    // control registers and conversion sequence
    //------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            chSel_r       <= `CCS_CH_RST;
            convOn_r      <= 1'b0;
            autoOn_r      <= 1'b0;
            irqEn_r       <= 1'b0;
            divSel_r      <= 3'h0;
            trigSel_r     <= 3'h0;
            doneFlag_r    <= 1'b0;
            busy_r        <= 1'b0;
            startPend_r   <= 1'b0;
            firstConv_r   <= 1'b1;
            cycLeft_r     <= 5'd0;
            result_r      <= 10'h000;
            analogChannel <= 4'h0;
            analogRefSupply <= 1'b0;
            tempSensorOn  <= 1'b0;
            analogSample  <= 1'b0;
        end else begin
            analogSample <= 1'b0;
            if (wrChSel)
                chSel_r <= wrData[7:0] & CH_LIVE_BITS;
            if (wrCtlB)
                trigSel_r <= wrData[2:0];
            if (wrCtlA) begin
                convOn_r <= wrData[`CCS_A_ON_BIT];
                autoOn_r <= wrData[`CCS_A_AUTO_BIT];
                irqEn_r  <= wrData[`CCS_A_IE_BIT];
                divSel_r <= wrData[2:0];
            end
            // a start written with the enable in one go also counts
            if (swStart && !busy_r)
                startPend_r <= 1'b1;
            else if (convOn_r && autoOn_r && trigRise && !busy_r)
                startPend_r <= 1'b1;
            else if (finish && autoOn_r && freeRun)
                startPend_r <= 1'b1;
            // selection follows the written value only while idle
            // limitation: following resumes as busy drops, not a converter cycle early
            if (!busy_r) begin
                analogChannel   <= chSel_r[3:0];
                analogRefSupply <= chSel_r[`CCS_CH_REF_BIT];
                tempSensorOn    <= (chSel_r[3:0] == `CCS_CH_TEMP_CODE);
            end
            if (convOn_r && !busy_r && startPend_r && tick) begin
                busy_r      <= 1'b1;
                startPend_r <= 1'b0;
                firstConv_r <= 1'b0;
                analogSample <= 1'b1;
                cycLeft_r   <= firstConv_r ? `CCS_FIRST_CYCLES : `CCS_NORM_CYCLES;
            end else if (busy_r && tick) begin
                cycLeft_r <= cycLeft_r - 5'd1;
                if (cycLeft_r == 5'd1) begin
                    busy_r <= 1'b0;
                    // result loads with the done flag unless a low byte read holds the lock
                    if (!lowRead_r)
                        result_r <= analogCode;
                end
            end
            // done flag: completion wins over a clear in the same cycle
            // acknowledge and a written one clear it alike
            if (finish)
                doneFlag_r <= 1'b1;
            else if (irqAck || (wrCtlA && wrData[`CCS_A_DONE_BIT]))
                doneFlag_r <= 1'b0;
            // turning off aborts and forces the next run to initialise
            if (abortNow) begin
                busy_r      <= 1'b0;
                startPend_r <= 1'b0;
                firstConv_r <= 1'b1;
                if (offWrite && finish)
                    doneFlag_r <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------------
    // result presentation and byte read lock
    //------------------------------------------------------------------
    // lock off: view follows the live result, justification applied at once
    assign shownCode  = lowRead_r ? shadow_r : result_r;
    assign resultView = chSel_r[`CCS_CH_LJ_BIT] ? {shownCode, 6'h00} : {6'h00, shownCode};
    // trade-off: the lock freezes the live result too, so a code finished meanwhile is lost
    assign resultRd       = rdFire && (s_axi_araddr[3:2] == OFF_RESULT[3:2]);
    assign readLowStrobe  = resultRd && (s_axi_araddr[1:0] == 2'b00);
    assign readHighStrobe = resultRd && s_axi_araddr[0];

    // low byte read freezes the pair until the high byte is read
    always @(posedge clk) begin
        if (rst) begin
            lowRead_r <= 1'b0;
            shadow_r  <= 10'h000;
        end else if (readLowStrobe) begin
            lowRead_r <= 1'b1;
            shadow_r  <= result_r;
        end else if (readHighStrobe) begin
            lowRead_r <= 1'b0;
        end
    end

    assign convDoneIrq = doneFlag_r && irqEn_r && globalIrqEnable;

    //------------------------------------------------------------------
    // read channel: one cycle answer, held until rready
    //------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rdFire        = s_axi_arvalid && s_axi_arready;

    always @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `CCS_RESP_OKAY;
        end else if (rdFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `CCS_RESP_OKAY;
            // start reads as pending or busy, so software sees it at once
            case (s_axi_araddr[3:2])
                2'h0:    s_axi_rdata <= {24'h000000, chSel_r};
                2'h1:    s_axi_rdata <= {24'h000000, convOn_r, busy_r || startPend_r,
                                         autoOn_r, doneFlag_r, irqEn_r, divSel_r};
                2'h2:    s_axi_rdata <= {29'h0000_0000, trigSel_r};
                default: s_axi_rdata <= {16'h0000, resultView};
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

`default_nettype wire

//--- test/ccs_sequencer_chk.sv
// port-level assertion checker for the converter control sequencer
`timescale 1ns/1ns
`default_nettype none
module ccs_sequencer_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic [3:0] analogChannel,
    input wire logic       analogRefSupply,
    input wire logic       tempSensorOn,
    input wire logic       analogSample,
    input wire logic       globalIrqEnable,
    input wire logic       convDoneIrq
);
    // ----------------------------------------
    // properties, all in the one clock domain
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // both write halves taken in one cycle, as our master offers them
    sequence s_wtake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_held;
        ($stable(analogChannel) && $stable(analogRefSupply)) [*8];
    endsequence
    property p_irq; !globalIrqEnable |-> !convDoneIrq; endproperty
    a_irq: assert property (p_irq) else $error("irq without global enable");
    property p_temp; tempSensorOn == (analogChannel == 4'h8); endproperty
    a_temp: assert property (p_temp) else $error("sensor enable mismatch");
    property p_lock; analogSample |=> s_held; endproperty
    a_lock: assert property (p_lock) else $error("mux moved mid conversion");
    property p_pulse; analogSample |=> !analogSample; endproperty
    a_pulse: assert property (p_pulse) else $error("start pulse too long");
    property p_wans; s_wtake |=> s_axi_bvalid; endproperty
    a_wans: assert property (p_wans) else $error("write answer missing");
    property p_err; s_wtake ##0 (s_axi_awaddr == 4'hC) |=> s_axi_bresp == 2'h2; endproperty
    a_err: assert property (p_err) else $error("result write not refused");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer missing");
    property p_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_refuse: assert property (p_refuse) else $error("read taken while answering");
    property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_busy: assert property (p_busy) else $error("write taken while answering");
endmodule

bind ccs_sequencer ccs_sequencer_chk ccs_sequencer_chk_inst (
    .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .analogChannel(analogChannel),
    .analogRefSupply(analogRefSupply), .tempSensorOn(tempSensorOn),
    .analogSample(analogSample), .globalIrqEnable(globalIrqEnable), .convDoneIrq(convDoneIrq)
);
`default_nettype wire

//--- test/ccs_analog_model.sv
// behavioural analog core: sample and hold with an ideal code
`timescale 1ns/1ns
`default_nettype none
module ccs_analog_model (
    input  wire logic       clk,
    input  wire logic [3:0] analogChannel,
    input  wire logic       analogRefSupply,
    input  wire logic       analogSample,
    output var  logic [9:0] analogCode
);
    // -----------------------------
    // code carries the mux choice
    // -----------------------------
    logic       held = 1'b0;
    logic [9:0] codeReg = 10'h155;
    assign analogCode = codeReg;
    // toggles until first sample so a premature latch shows up
    always @(posedge clk) begin
        if (analogSample) begin
            codeReg <= {analogChannel, analogRefSupply, 5'h0A};
            held <= 1'b1;
        end else if (!held) begin
            codeReg <= ~codeReg;
        end
    end
endmodule
`default_nettype wire

//--- test/ccs_sequencer_tb.sv
// self-checking bench for the converter control sequencer
`timescale 1ns/1ns
`default_nettype none
module ccs_sequencer_tb;
    // -----------------------------
    // stimulus and design
    // -----------------------------
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  awAddr = 4'h0;
    logic [3:0]  arAddr = 4'h0;
    logic [31:0] wData = 32'h0;
    logic        awValid = 1'b0;
    logic        wValid = 1'b0;
    logic        bReady = 1'b0;
    logic        arValid = 1'b0;
    logic        rReady = 1'b0;
    logic        gIe = 1'b1;
    logic        irqAck = 1'b0;
    logic [7:0]  trig = 8'h00;
    wire         awReady, wReady, bValid, arReady, rValid, aRef, tOn, aSmp, irq;
    wire [1:0]   bResp;
    wire [1:0]   rResp;
    wire         lowStb, hiStb;
    wire [31:0]  rData;
    wire [3:0]   aCh;
    wire [9:0]   aCode;
    integer      n_fail = 0;
    integer      compares = 0;
    integer      cyc = 0;
    integer      t0, i;

    ccs_sequencer ccs_sequencer_inst (
        .clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .analogChannel(aCh), .analogRefSupply(aRef), .tempSensorOn(tOn),
        .analogSample(aSmp), .analogCode(aCode), .triggerSources(trig),
        .globalIrqEnable(gIe), .irqAck(irqAck), .convDoneIrq(irq),
        .readLowStrobe(lowStb), .readHighStrobe(hiStb)
    );
    ccs_analog_model ccs_analog_model_inst (
        .clk(clk), .analogChannel(aCh), .analogRefSupply(aRef),
        .analogSample(aSmp), .analogCode(aCode)
    );

    always #5 clk = ~clk;
    // cycle count doubles as the hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            wrap_up;
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // write cycle: each half released once taken, bready held until answer
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            awAddr <= a;
            wData <= d;
            awValid <= 1'b1;
            wValid <= 1'b1;
            bReady <= 1'b1;
            do begin
                @(posedge clk);
                if (awReady === 1'b1) awValid <= 1'b0;
                if (wReady === 1'b1) wValid <= 1'b0;
            end while ((awValid && awReady !== 1'b1) || (wValid && wReady !== 1'b1));
            while (bValid !== 1'b1) @(posedge clk);
            bReady <= 1'b0;
            chk("bresp", bResp, (a == 4'hC) ? 2 : 0);
        end
    endtask
    // read cycle with comparison of the low half word
    task rc(input [3:0] a, input [31:0] e);
        begin
            @(posedge clk);
            arAddr <= a;
            arValid <= 1'b1;
            rReady <= 1'b1;
            do @(posedge clk); while (arReady !== 1'b1);
            arValid <= 1'b0;
            chk("lowstrobe", lowStb, a == 4'hC);
            chk("highstrobe", hiStb, a == 4'hD);
            while (rValid !== 1'b1) @(posedge clk);
            rReady <= 1'b0;
            chk("rdata", rData[15:0], e);
            chk("rresp", rResp, 0);
        end
    endtask
    // wait for completion; n ticks of d cycles judged when n is nonzero
    task wirq(input integer n, input integer d);
        integer s;
        begin
            s = cyc;
            while (irq !== 1'b1 && cyc - s < 3000) @(posedge clk);
            chk("completion", irq, 1);
            if (n > 0) chk("duration", (cyc - t0 >= n * d - 2) && (cyc - t0 <= n * d + d + 4), 1);
        end
    endtask
    task wrap_up;
        begin
            if (n_fail == 0 && compares > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask

    // -----------------------------
    // test sequence
    // -----------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rc(4'h0, 0);
        rc(4'h4, 0);
        wr(4'hC, 0);
        wr(4'h0, 32'hFF);
        rc(4'h0, 32'h6F);
        // every defined channel code, reference following the low bit
        for (i = 0; i < 16; i = i + 1) begin
            if (i < 9 || i > 13) begin
                wr(4'h0, {25'h0, i[0], 2'b00, i[3:0]});
                repeat (2) @(posedge clk);
                chk("channel", aCh, i[3:0]);
                chk("sensor", tOn, i == 8);
                chk("ref", aRef, i[0]);
            end
        end
        // first conversion, mux rewritten while it runs
        wr(4'h0, 32'h43);
        wr(4'h4, 32'hC8);
        t0 = cyc;
        rc(4'h4, 32'hC8);
        wr(4'h0, 32'h05);
        chk("channel", aCh, 3);
        chk("ref", aRef, 1);
        wirq(25, 2);
        rc(4'h4, 32'h98);
        rc(4'hC, 32'h00EA);
        rc(4'hD, 32'h00EA);
        wr(4'h0, 32'h25);
        rc(4'hC, 32'h3A80);
        rc(4'hD, 32'h3A80);
        // whole values written, never read back and modified
        wr(4'h4, 32'h98);
        chk("irq", irq, 0);
        wr(4'h4, 32'hCB);
        t0 = cyc;
        wirq(13, 8);
        rc(4'hC, 32'h5280);
        // low byte read holds the shown code over a new conversion
        wr(4'h0, 32'h27);
        wr(4'h4, 32'h9B);
        wr(4'h4, 32'hCB);
        t0 = cyc;
        wirq(13, 8);
        rc(4'hD, 32'h5280);
        irqAck <= 1'b1;
        @(posedge clk);
        irqAck <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq", irq, 0);
        // trigger edge with the global enable off
        gIe <= 1'b0;
        wr(4'h8, 32'h01);
        wr(4'h4, 32'hAB);
        trig <= 8'h02;
        repeat (3) @(posedge clk);
        trig <= 8'h00;
        repeat (200) @(posedge clk);
        chk("irq", irq, 0);
        rc(4'h4, 32'hBB);
        gIe <= 1'b1;
        repeat (2) @(posedge clk);
        chk("irq", irq, 1);
        // free running: a second completion with no new start
        wr(4'h8, 32'h00);
        wr(4'h4, 32'hFB);
        wirq(0, 8);
        wr(4'h4, 32'hBB);
        wirq(0, 8);
        chk("irq", irq, 1);
        // switching off mid conversion aborts it
        wr(4'h4, 32'h1B);
        wr(4'h4, 32'hCB);
        repeat (20) @(posedge clk);
        wr(4'h4, 32'h0B);
        rc(4'h4, 32'h0B);
        repeat (400) @(posedge clk);
        chk("irq", irq, 0);
        // temperature: internal reference and single mode, as software must
        wr(4'h0, 32'h08);
        wr(4'h4, 32'hCB);
        t0 = cyc;
        chk("sensor", tOn, 1);
        wirq(25, 8);
        rc(4'hC, 32'h020A);
        rc(4'hD, 32'h020A);
        wrap_up;
    end
endmodule
`default_nettype wire
